/* File: rtl/clock_expression_qualifier.sv */
// Qualifier that turns probe expressions into master and section sample events
`timescale 1ns/1ns
module clock_expression_qualifier
	import clkexpr_pkg::*;
#(
	parameter int PROBE_W = PROBE_W_DEF,
	parameter int NUM_SECT = NUM_SECT_DEF,
	parameter int SEL_W = $clog2(PROBE_W)
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [PROBE_W-1:0] probe_in,
	input wire logic [(NUM_SECT+1)*NUM_TERMS*SEL_W-1:0] term_sel,
	input wire logic [(NUM_SECT+1)*NUM_TERMS-1:0] term_pol,
	input wire logic [(NUM_SECT+1)*NUM_TERMS-1:0] term_en,
	input wire logic [(NUM_SECT+1)*NUM_NODES-1:0] node_op,
	input wire logic [NUM_SECT-1:0] sect_same_as_master,
	output logic master_result,
	output logic master_pulse,
	output logic [NUM_SECT-1:0] sect_result,
	output logic [NUM_SECT-1:0] sect_pulse
);

	localparam int NUM_EXPR = NUM_SECT + 1;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (PROBE_W < 2) begin : g_chk_probe
		$error("PROBE_W must be at least 2");
	end
	if (NUM_SECT < 1) begin : g_chk_sect
		$error("NUM_SECT must be at least 1");
	end
	if (SEL_W < $clog2(PROBE_W)) begin : g_chk_sel
		$error("SEL_W too narrow for PROBE_W");
	end

	// ****************************************
	// Term evaluation
	// ****************************************
	function automatic logic term_level(
		input logic [PROBE_W-1:0] probes,
		input logic [SEL_W-1:0] sel,
		input logic pol
	);
		logic lvl;
		lvl = 1'h0;
		if (int'(sel) < PROBE_W) begin
			lvl = probes[sel];
		end
		if (pol == POL_UP) begin
			term_level = lvl;
		end else begin
			term_level = ~lvl;
		end
	endfunction : term_level

	// ****************************************
	// Probe capture
	// ****************************************
	logic [PROBE_W-1:0] probe_ff;
	logic [PROBE_W-1:0] nxt_probe;

	always_comb begin
		nxt_probe = probe_in;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			probe_ff <= '0;
		end else begin
			probe_ff <= nxt_probe;
		end
	end

	// ****************************************
	// Expression trees
	// ****************************************
	logic [NUM_EXPR-1:0] expr_now;

	for (genvar e = 0; e < NUM_EXPR; e++) begin : g_expr
		logic [NUM_TERMS-1:0] t_val;
		logic [NUM_TERMS-1:0] t_vld;
		logic [NUM_NODES-1:0] n_val;
		logic [NUM_NODES-1:0] n_vld;
		logic [NUM_NODES-1:0] ops;

		assign ops = node_op[e*NUM_NODES +: NUM_NODES];

		for (genvar k = 0; k < NUM_TERMS; k++) begin : g_term
			localparam int IDX = e * NUM_TERMS + k;
			assign t_val[k] = term_level(probe_ff, term_sel[IDX*SEL_W +: SEL_W], term_pol[IDX]);
			assign t_vld[k] = term_en[IDX];
		end

		// Three leaf pairs of input terms
		for (genvar p = 0; p < 3; p++) begin : g_leaf
			pair_node u_leaf (
				.a_val(t_val[2*p]),
				.a_vld(t_vld[2*p]),
				.b_val(t_val[2*p+1]),
				.b_vld(t_vld[2*p+1]),
				.op_sel(ops[p]),
				.r_val(n_val[p]),
				.r_vld(n_vld[p])
			);
		end

		// Pair results reused as terms of further pairs
		pair_node u_inner (
			.a_val(n_val[NODE_PAIR_A]),
			.a_vld(n_vld[NODE_PAIR_A]),
			.b_val(n_val[NODE_PAIR_B]),
			.b_vld(n_vld[NODE_PAIR_B]),
			.op_sel(ops[NODE_INNER]),
			.r_val(n_val[NODE_INNER]),
			.r_vld(n_vld[NODE_INNER])
		);

		pair_node u_outer (
			.a_val(n_val[NODE_INNER]),
			.a_vld(n_vld[NODE_INNER]),
			.b_val(n_val[NODE_PAIR_C]),
			.b_vld(n_vld[NODE_PAIR_C]),
			.op_sel(ops[NODE_OUTER]),
			.r_val(n_val[NODE_OUTER]),
			.r_vld(n_vld[NODE_OUTER])
		);

		// An expression without any enabled term stays false
		assign expr_now[e] = n_val[NODE_OUTER] & n_vld[NODE_OUTER];
	end

	// ****************************************
	// Result registers and warm-up
	// ****************************************
	logic [NUM_EXPR-1:0] res_ff;
	logic [NUM_EXPR-1:0] prev_ff;
	logic [1:0] warm_ff;
	logic [NUM_EXPR-1:0] nxt_res;
	logic [NUM_EXPR-1:0] nxt_prev;
	logic [1:0] nxt_warm;

	always_comb begin
		nxt_res = expr_now;
		nxt_prev = res_ff;
		nxt_warm = warm_ff;
		if (warm_ff != WARM_CYCLES) begin
			nxt_warm = warm_ff + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			res_ff <= {NUM_EXPR{RESULT_RST}};
			prev_ff <= {NUM_EXPR{RESULT_RST}};
			warm_ff <= WARM_RST;
		end else begin
			res_ff <= nxt_res;
			prev_ff <= nxt_prev;
			warm_ff <= nxt_warm;
		end
	end

	// ****************************************
	// Rising edge events
	// ****************************************
	logic [NUM_EXPR-1:0] rise;
	logic nxt_master_pulse;
	logic [NUM_SECT-1:0] nxt_sect_pulse;
	logic master_pulse_ff;
	logic [NUM_SECT-1:0] sect_pulse_ff;
	logic master_result_ff;
	logic [NUM_SECT-1:0] sect_result_ff;

	always_comb begin
		// Only a false to true change counts; a true result holds no event
		rise = res_ff & ~prev_ff;
		if (warm_ff != WARM_CYCLES) begin
			rise = '0;
		end
		nxt_master_pulse = rise[0];
		for (int s = 0; s < NUM_SECT; s++) begin
			if (sect_same_as_master[s]) begin
				nxt_sect_pulse[s] = rise[0];
			end else begin
				nxt_sect_pulse[s] = rise[s+1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			master_pulse_ff <= PULSE_RST;
			sect_pulse_ff <= {NUM_SECT{PULSE_RST}};
			master_result_ff <= RESULT_RST;
			sect_result_ff <= {NUM_SECT{RESULT_RST}};
		end else begin
			master_pulse_ff <= nxt_master_pulse;
			sect_pulse_ff <= nxt_sect_pulse;
			master_result_ff <= res_ff[0];
			sect_result_ff <= res_ff[NUM_EXPR-1:1];
		end
	end

	assign master_pulse = master_pulse_ff;
	assign sect_pulse = sect_pulse_ff;
	assign master_result = master_result_ff;
	assign sect_result = sect_result_ff;

endmodule : clock_expression_qualifier

/* File: common/clkexpr_pkg.sv */
// Constants shared by the clock expression qualifier
//
// Contract
// - A sample event fires only when the combined expression goes false to true.
// - While the expression is already true, further satisfying changes give no event.
// - Each term has polarity: up counts high as true, down counts low as true.
// - An OR pair is true when either term is true.
// - An AND pair is true only when both terms are true.
// - A term that already decides its pair masks every change of its partner.
// - Pair results feed further pairs, up to six input terms per expression.
// - Master and section sample clocks capture on the expression's rising edge.
package clkexpr_pkg;

	// ****************************************
	// Expression shape
	// ****************************************
	localparam int NUM_TERMS = 6;
	localparam int NUM_NODES = 5;
	localparam int NODE_PAIR_A = 0;
	localparam int NODE_PAIR_B = 1;
	localparam int NODE_PAIR_C = 2;
	localparam int NODE_INNER = 3;
	localparam int NODE_OUTER = 4;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic OP_OR = 1'h0;
	localparam logic OP_AND = 1'h1;
	localparam logic POL_DOWN = 1'h0;
	localparam logic POL_UP = 1'h1;

	// ****************************************
	// Defaults, reset values and timing
	// ****************************************
	localparam int PROBE_W_DEF = 48;
	localparam int NUM_SECT_DEF = 3;
	localparam logic [1:0] WARM_CYCLES = 2'h3;
	localparam logic [1:0] WARM_RST = 2'h0;
	localparam logic RESULT_RST = 1'h0;
	localparam logic PULSE_RST = 1'h0;

endpackage : clkexpr_pkg

/* File: rtl/pair_node.sv */
// One two-input node of a clock expression
`timescale 1ns/1ns
module pair_node
	import clkexpr_pkg::*;
(
	input wire logic a_val,
	input wire logic a_vld,
	input wire logic b_val,
	input wire logic b_vld,
	input wire logic op_sel,
	output logic r_val,
	output logic r_vld
);

	// ****************************************
	// Combine the two inputs
	// ****************************************
	always_comb begin
		r_vld = a_vld | b_vld;
		if (a_vld && b_vld) begin
			if (op_sel == OP_AND) begin
				r_val = a_val & b_val;
			end else begin
				r_val = a_val | b_val;
			end
		end else if (a_vld) begin
			r_val = a_val;
		end else if (b_vld) begin
			r_val = b_val;
		end else begin
			r_val = 1'h0;
		end
	end

endmodule : pair_node

/* File: verif/clkq_props.sv */
// Checker for the clock expression qualifier outputs
`timescale 1ns/1ns
module clkq_props #(parameter int NUM_SECT = 3)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NUM_SECT-1:0] sect_same_as_master,
	input wire logic master_result,
	input wire logic master_pulse,
	input wire logic [NUM_SECT-1:0] sect_result,
	input wire logic [NUM_SECT-1:0] sect_pulse
);
	// ****
	// Assertions
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	pulse_on_rise_a: assert property (master_pulse |-> $rose(master_result))
		else $error("pulse without rise");
	pulse_gap_a: assert property (master_pulse |=> !master_pulse)
		else $error("back to back pulse");
	sect_rise_a: assert property ($stable(sect_same_as_master) |->
		(sect_pulse & ~sect_same_as_master & ~(sect_result & ~$past(sect_result))) == '0)
		else $error("section pulse without rise");
	sect_follow_a: assert property (sect_same_as_master[0] && $past(sect_same_as_master[0])
		|-> sect_pulse[0] == master_pulse)
		else $error("section not following master");
	reset_clear_a: assert property (disable iff (1'b0) !resetn |=>
		!master_result && !master_pulse && sect_result == '0 && sect_pulse == '0)
		else $error("outputs not cleared");
	warm_up_a: assert property ($rose(resetn) |=> !master_pulse [*3])
		else $error("pulse in warm up");
	sect_warm_a: assert property ($rose(resetn) |=> (sect_pulse == '0) [*3])
		else $error("section pulse in warm up");
	sect_gap_a: assert property (sect_pulse[1] |=> !sect_pulse[1])
		else $error("back to back section pulse");
	cover property (master_pulse);
	cover property (sect_pulse[1] && !sect_same_as_master[1]);
	cover property (sect_pulse[0] && sect_same_as_master[0]);
endmodule : clkq_props

/* File: verif/target_probes.sv */
// Model of the probed target control lines
`timescale 1ns/1ns
module target_probes #(parameter int PROBE_W = 48)
(
	input wire logic clk,
	input wire logic [PROBE_W-1:0] nxt_lines,
	output logic [PROBE_W-1:0] lines_ff
);
	always @(posedge clk) begin
		lines_ff <= nxt_lines;
	end
endmodule : target_probes

/* File: verif/clock_expression_qualifier_tb.sv */
// Testbench for the clock expression qualifier
`timescale 1ns/1ns
module clock_expression_qualifier_tb
	import clkexpr_pkg::*;
;
	localparam int NS = NUM_SECT_DEF;
	localparam int SW = $clog2(PROBE_W_DEF);
	logic clk = 0, resetn = 0, live = 0, master_result, master_pulse;
	logic [PROBE_W_DEF-1:0] nxt_lines = '0, probe_in;
	logic [(NS+1)*NUM_TERMS*SW-1:0] term_sel = '0;
	logic [(NS+1)*NUM_TERMS-1:0] term_pol = '0, term_en = '0;
	logic [(NS+1)*NUM_NODES-1:0] node_op = '0;
	logic [NS-1:0] same_sel = '0, sect_result, sect_pulse;
	logic [3:0] hist [NS+1];
	logic [31:0] lfsr = 32'hd695;
	int err_count = 0, checks_done = 0;
	// ****
	// Models and checks
	// ****
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 32; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic [1:0] nd(input logic [1:0] a, input logic [1:0] b, input logic op);
		if (!a[1]) return b;
		if (!b[1]) return a;
		return {1'b1, op ? a[0] & b[0] : a[0] | b[0]};
	endfunction : nd
	function automatic logic expr(input int e, input logic [PROBE_W_DEF-1:0] p);
		logic [1:0] t [NUM_TERMS];
		logic [1:0] n [NUM_NODES];
		logic [SW-1:0] s;
		for (int k = 0; k < NUM_TERMS; k++) begin
			s = term_sel[(e*NUM_TERMS+k)*SW +: SW];
			t[k] = {term_en[e*NUM_TERMS+k], (s < PROBE_W_DEF ? p[s] : 1'b0) ~^ term_pol[e*NUM_TERMS+k]};
		end
		for (int k = 0; k < 3; k++) n[k] = nd(t[2*k], t[2*k+1], node_op[e*NUM_NODES+k]);
		n[3] = nd(n[0], n[1], node_op[e*NUM_NODES+3]);
		n[4] = nd(n[3], n[2], node_op[e*NUM_NODES+4]);
		return n[4][1] & n[4][0];
	endfunction : expr
	function automatic logic rose_at(input int e);
		return hist[e][2] & ~hist[e][3];
	endfunction : rose_at
	task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		for (int e = 0; e <= NS; e++) hist[e] <= {hist[e][2:0], expr(e, probe_in)};
	end
	always @(negedge clk) begin
		if (live) begin
			chk("master_result", master_result, hist[0][2]);
			chk("master_pulse", master_pulse, rose_at(0));
			for (int s = 0; s < NS; s++) begin
				chk("sect_result", sect_result[s], hist[s+1][2]);
				chk("sect_pulse", sect_pulse[s], rose_at(same_sel[s] ? 0 : s + 1));
			end
		end
	end
	// ****
	// Stimulus
	// ****
	task automatic setup(input int i);
		logic [159:0] s;
		logic [31:0] p, q, o, a, b;
		s = {rnd(), rnd(), rnd(), rnd(), rnd()};
		p = rnd();
		q = rnd();
		o = rnd();
		if (i < 9) begin
			s[11:0] = 12'h0040;
			p[5:0] = {4'h0, i[0], i[1]};
			q[5:0] = (i == 8) ? 6'h01 : 6'h03;
			o[0] = i[2];
		end
		@(posedge clk);
		live <= 1'b0;
		term_sel <= s[143:0];
		term_pol <= p[23:0];
		term_en <= q[23:0];
		node_op <= o[19:0];
		same_sel <= o[22:20];
		repeat (5) @(posedge clk);
		live <= 1'b1;
		repeat (60) begin
			@(posedge clk);
			a = rnd();
			b = rnd();
			if (a[31]) nxt_lines <= {a[15:0], b};
		end
	endtask : setup
	clock_expression_qualifier u_dut (.clk(clk), .resetn(resetn), .probe_in(probe_in),
		.term_sel(term_sel), .term_pol(term_pol), .term_en(term_en), .node_op(node_op),
		.sect_same_as_master(same_sel), .master_result(master_result), .master_pulse(master_pulse),
		.sect_result(sect_result), .sect_pulse(sect_pulse));
	target_probes u_probes (.clk(clk), .nxt_lines(nxt_lines), .lines_ff(probe_in));
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		#50000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 40; i++) setup(i);
		@(posedge clk);
		resetn <= 1'b0;
		live <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		setup(5);
		wrap_up();
	end
endmodule : clock_expression_qualifier_tb
bind clock_expression_qualifier clkq_props #(.NUM_SECT(NUM_SECT)) u_props (.clk(clk), .resetn(resetn),
	.sect_same_as_master(sect_same_as_master), .master_result(master_result), .master_pulse(master_pulse),
	.sect_result(sect_result), .sect_pulse(sect_pulse));
